// ===== rtl/pldlut_pkg.sv
package pldlut_pkg;

    // Table offsets on the register port
    localparam logic [7:0] LUT_A_FIRST_OFS  = 8'h27;
    localparam logic [7:0] LUT_B_SECOND_OFS = 8'h28;
    localparam logic [7:0] LUT_A_SECOND_OFS = 8'h29;
    localparam logic [7:0] LUT_B_THIRD_OFS  = 8'h2a;
    localparam logic [7:0] LUT_A_THIRD_OFS  = 8'h2b;
    localparam logic [7:0] LUT_BASE_OFS     = LUT_A_FIRST_OFS;
    localparam logic [7:0] LUT_LAST_OFS     = LUT_A_THIRD_OFS;
    localparam int         LUT_COUNT        = 5;

    // Table index: offset minus base
    localparam logic [2:0] LUT_A_FIRST_IDX  = 3'h0;
    localparam logic [2:0] LUT_B_SECOND_IDX = 3'h1;
    localparam logic [2:0] LUT_A_SECOND_IDX = 3'h2;
    localparam logic [2:0] LUT_B_THIRD_IDX  = 3'h3;
    localparam logic [2:0] LUT_A_THIRD_IDX  = 3'h4;

    // Reset values
    localparam logic [7:0] LUT_RESET        = 8'h00;
    localparam logic [7:0] RDATA_RESET      = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA   = 8'h00;

    // Line positions
    localparam int         IO_WIDTH         = 16;
    localparam int         A_IN_LSB         = 0;
    localparam int         A_OUT_FIRST      = 3;
    localparam int         A_OUT_SECOND     = 4;
    localparam int         B_IN_LSB         = 8;
    localparam int         B_OUT_FIRST      = 11;
    localparam int         B_OUT_SECOND     = 12;

    typedef enum logic [1:0] {
        PLDLUT_MODE_GPIO,
        PLDLUT_MODE_3TO1,
        PLDLUT_MODE_3TO2,
        PLDLUT_MODE_RSVD
    } pldlut_mode_t;

endpackage

// ===== rtl/pldlut_sync.sv
`timescale 1ns/1ps
module pldlut_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // Two flops; the first is read only by the second
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule // pldlut_sync

// ===== rtl/pldlut_top.sv
`timescale 1ns/1ps
// How it works
// - A low 3-to-1: line 3 from first table
// - B low 3-to-2: line 11 from 0x28
// - B low 3-to-2: line 12 from 0x2A
// - A low 3-to-2: line 3 from 0x29
// - Tables act only in their selected mode
// - Table bit n serves input value n
// - Tables 0x28, 0x29, 0x2A reset to zero
// - A low 3-to-2: line 4 from 0x2B
// - First A table at 0x27, resets zero
module pldlut_top
    import pldlut_pkg::*;
(
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    input  wire pldlut_pkg::pldlut_mode_t      bank_a_low_logic_mode,
    input  wire pldlut_pkg::pldlut_mode_t      bank_b_low_logic_mode,
    input  wire logic [pldlut_pkg::IO_WIDTH-1:0] io_in,
    output logic      [pldlut_pkg::IO_WIDTH-1:0] io_out,
    output logic      [pldlut_pkg::IO_WIDTH-1:0] io_oe_n
);
    import pldlut_pkg::*;

    logic [7:0]          lut_reg [LUT_COUNT];
    logic [IO_WIDTH-1:0] pin_sync;
    logic [IO_WIDTH-1:0] io_out_next;
    logic [IO_WIDTH-1:0] io_oe_n_next;
    logic [7:0]          reg_rdata_next;

    // Pin inputs cross into the core clock domain
    pldlut_sync #(
        .WIDTH    (IO_WIDTH)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (io_in),
        .sync_out (pin_sync)
    );

    // Register decode
    wire logic [7:0] addr_off = reg_addr - LUT_BASE_OFS;
    wire logic [2:0] lut_idx  = addr_off[2:0];
    wire logic       lut_hit  = (reg_addr >= LUT_BASE_OFS) &&
                                (reg_addr <= LUT_LAST_OFS);

    // Table storage, one entry per offset
    generate
        for (genvar t = 0; t < LUT_COUNT; t++) begin : g_lut
            wire logic wr_sel = reg_wr && lut_hit &&
                                (lut_idx == 3'(t));
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    lut_reg[t] <= LUT_RESET;
                end else if (wr_sel) begin
                    lut_reg[t] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Read data, unmapped offsets read zero
    assign reg_rdata_next = !reg_rd  ? reg_rdata :
                            lut_hit  ? lut_reg[lut_idx] :
                                       UNMAPPED_RDATA;

    // Input groups select one table bit each
    wire logic [2:0] a_sel = pin_sync[A_IN_LSB +: 3];
    wire logic [2:0] b_sel = pin_sync[B_IN_LSB +: 3];

    wire logic a_3to1 = bank_a_low_logic_mode == PLDLUT_MODE_3TO1;
    wire logic a_3to2 = bank_a_low_logic_mode == PLDLUT_MODE_3TO2;
    wire logic b_3to2 = bank_b_low_logic_mode == PLDLUT_MODE_3TO2;

    // Bit n of a table answers input value n
    wire logic a_first_bit  = a_3to1 ?
                              lut_reg[LUT_A_FIRST_IDX][a_sel] :
                              lut_reg[LUT_A_SECOND_IDX][a_sel];
    wire logic a_second_bit = lut_reg[LUT_A_THIRD_IDX][a_sel];
    wire logic b_first_bit  = lut_reg[LUT_B_SECOND_IDX][b_sel];
    wire logic b_second_bit = lut_reg[LUT_B_THIRD_IDX][b_sel];

    wire logic drv_a_first  = a_3to1 || a_3to2;
    wire logic drv_a_second = a_3to2;
    wire logic drv_b_first  = b_3to2;
    wire logic drv_b_second = b_3to2;

    // Per-line output select; undriven lines are released
    generate
        for (genvar i = 0; i < IO_WIDTH; i++) begin : g_line
            wire logic drv = (i == A_OUT_FIRST)  ? drv_a_first  :
                             (i == A_OUT_SECOND) ? drv_a_second :
                             (i == B_OUT_FIRST)  ? drv_b_first  :
                             (i == B_OUT_SECOND) ? drv_b_second :
                                                   1'b0;
            wire logic val = (i == A_OUT_FIRST)  ? a_first_bit  :
                             (i == A_OUT_SECOND) ? a_second_bit :
                             (i == B_OUT_FIRST)  ? b_first_bit  :
                             (i == B_OUT_SECOND) ? b_second_bit :
                                                   1'b0;
            assign io_out_next[i]  = drv & val;
            assign io_oe_n_next[i] = ~drv;
        end
    endgenerate

    // Pin outputs follow every cycle with no trigger; reg_rdata loads only on reg_rd
    always_ff @(posedge core_clk) begin
        if (rst) begin
            io_out    <= '0;
            io_oe_n   <= '1;
            reg_rdata <= RDATA_RESET;
        end else begin
            io_out    <= io_out_next;
            io_oe_n   <= io_oe_n_next;
            reg_rdata <= reg_rdata_next;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_tables_reset: assert property (
        $past(rst) |-> (lut_reg[LUT_B_SECOND_IDX] == LUT_RESET) &&
                       (lut_reg[LUT_A_SECOND_IDX] == LUT_RESET) &&
                       (lut_reg[LUT_B_THIRD_IDX] == LUT_RESET))
        else $error("tables not zero after reset");

    a_first_table_reset: assert property (
        $past(rst) |-> lut_reg[LUT_A_FIRST_IDX] == LUT_RESET &&
                       io_out == '0)
        else $error("first table or outputs not zero after reset");

    a_a_3to1_line: assert property (
        a_3to1 |=> !io_oe_n[A_OUT_FIRST] && io_oe_n[A_OUT_SECOND] &&
            io_out[A_OUT_FIRST] ==
            $past(lut_reg[LUT_A_FIRST_IDX][pin_sync[2:0]]))
        else $error("line 3 wrong in 3-to-1 mode");

    a_b_first_line: assert property (
        b_3to2 |=> !io_oe_n[B_OUT_FIRST] &&
            io_out[B_OUT_FIRST] ==
            $past(lut_reg[LUT_B_SECOND_IDX][pin_sync[10:8]]))
        else $error("line 11 wrong in 3-to-2 mode");

    a_b_second_line: assert property (
        b_3to2 |=> !io_oe_n[B_OUT_SECOND] &&
            io_out[B_OUT_SECOND] ==
            $past(lut_reg[LUT_B_THIRD_IDX][pin_sync[10:8]]))
        else $error("line 12 wrong in 3-to-2 mode");

    a_a_first_line: assert property (
        a_3to2 |=> !io_oe_n[A_OUT_FIRST] &&
            io_out[A_OUT_FIRST] ==
            $past(lut_reg[LUT_A_SECOND_IDX][pin_sync[2:0]]))
        else $error("line 3 wrong in 3-to-2 mode");

    a_a_second_line: assert property (
        a_3to2 |=> !io_oe_n[A_OUT_SECOND] &&
            io_out[A_OUT_SECOND] ==
            $past(lut_reg[LUT_A_THIRD_IDX][pin_sync[2:0]]))
        else $error("line 4 wrong in 3-to-2 mode");

    a_idle_released: assert property (
        (bank_a_low_logic_mode == PLDLUT_MODE_GPIO) &&
        !b_3to2 |=> io_oe_n == '1 && io_out == '0)
        else $error("line driven outside its mode");

    a_pin_index: assert property (
        a_3to1 && (io_in[2:0] == 3'h7) ##1
        (a_3to1 && $stable(io_in[2:0]))[*2] |=>
        io_out[A_OUT_FIRST] == $past(lut_reg[LUT_A_FIRST_IDX][7]))
        else $error("input 111 did not select bit 7");

    sequence s_write_a_second;
        reg_wr && (reg_addr == LUT_A_SECOND_OFS) && a_3to2;
    endsequence

    sequence s_hold_a_second;
        a_3to2 && $stable(pin_sync[2:0]) && !reg_wr;
    endsequence

    a_write_reaches: assert property (
        s_write_a_second ##1 s_hold_a_second |=>
        io_out[A_OUT_FIRST] == $past(reg_wdata[pin_sync[2:0]], 2))
        else $error("table write did not reach line 3");

    a_read_back: assert property (
        reg_rd && lut_hit |=> reg_rdata == $past(lut_reg[lut_idx]))
        else $error("table read back wrong");

    a_unmapped_zero: assert property (
        reg_rd && !lut_hit |=> reg_rdata == UNMAPPED_RDATA)
        else $error("unmapped read not zero");

    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_a_released: assert property (
        !a_3to1 && !a_3to2 |=> io_oe_n[A_OUT_FIRST] &&
            io_oe_n[A_OUT_SECOND] && !io_out[A_OUT_FIRST] &&
            !io_out[A_OUT_SECOND])
        else $error("bank A line driven outside its mode");

    a_b_released: assert property (
        !b_3to2 |=> io_oe_n[B_OUT_FIRST] && io_oe_n[B_OUT_SECOND] &&
            !io_out[B_OUT_FIRST] && !io_out[B_OUT_SECOND])
        else $error("bank B line driven outside its mode");

    a_spare_released: assert property (
        1'b1 |=> &io_oe_n[2:0] && &io_oe_n[10:5] && &io_oe_n[15:13])
        else $error("spare line driven");

    sequence s_write_b_second;
        reg_wr && (reg_addr == LUT_B_SECOND_OFS) && b_3to2;
    endsequence

    sequence s_hold_b_second;
        b_3to2 && $stable(b_sel) && !reg_wr;
    endsequence

    a_b_write_reaches: assert property (
        s_write_b_second ##1 s_hold_b_second |=>
        io_out[B_OUT_FIRST] == $past(reg_wdata[b_sel], 2))
        else $error("table write did not reach line 11");

endmodule // pldlut_top

// ===== verif/pldlut_pins_model.sv
`timescale 1ns/1ps
module pldlut_pins_model (
    input  wire logic        core_clk,
    input  wire logic [2:0]  sel_a,
    input  wire logic [2:0]  sel_b,
    input  wire logic [15:0] io_out,
    input  wire logic [15:0] io_oe_n,
    output logic      [15:0] io_in
);
    logic [15:0] drv;
    logic        tog = 1'b0;
    // Lines nobody selects change every cycle
    always @(negedge core_clk) begin
        tog <= ~tog;
    end
    always_comb begin
        drv = {16{tog}};
        drv[2:0] = sel_a;
        drv[10:8] = sel_b;
    end
    // Device wins wherever it drives
    assign io_in = (io_out & ~io_oe_n) | (drv & io_oe_n);
endmodule // pldlut_pins_model

// ===== verif/pldlut_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    bad_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module pldlut_top_bench;
    import pldlut_pkg::*;
    logic         core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    pldlut_mode_t mode_a = PLDLUT_MODE_GPIO, mode_b = PLDLUT_MODE_GPIO;
    logic [2:0]   sel_a = 3'h0, sel_b = 3'h0;
    logic [15:0]  io_in, io_out, io_oe_n;
    int           bad_count = 0, n_tests = 0;

    pldlut_top uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bank_a_low_logic_mode(mode_a),
        .bank_b_low_logic_mode(mode_b), .io_in(io_in), .io_out(io_out),
        .io_oe_n(io_oe_n));
    pldlut_pins_model pins_far (.core_clk(core_clk), .sel_a(sel_a),
        .sel_b(sel_b), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    // Set both selects, let sync and output flops settle, check four lines
    task automatic pins(input logic [2:0] s, input logic [3:0] eo,
                        input logic [3:0] en);
        @(negedge core_clk);
        sel_a = s;
        sel_b = s;
        repeat (4) @(negedge core_clk);
        `CHK("out", eo, {io_out[12], io_out[11], io_out[4], io_out[3]})
        `CHK("oe_n", en, {io_oe_n[12], io_oe_n[11], io_oe_n[4], io_oe_n[3]})
    endtask

    task automatic t_reset;
        `CHK("oe_n all", 16'hffff, io_oe_n)
        `CHK("out all", 16'h0000, io_out)
        for (int i = 0; i < LUT_COUNT; i++) begin
            rd(LUT_BASE_OFS + 8'(i), LUT_RESET);
        end
    endtask

    task automatic t_regs;
        for (int i = 0; i < LUT_COUNT; i++) begin
            wr(LUT_BASE_OFS + 8'(i), 8'h11 * 8'(i + 1));
        end
        wr(8'h2c, 8'hff);
        for (int i = 0; i < LUT_COUNT; i++) begin
            rd(LUT_BASE_OFS + 8'(i), 8'h11 * 8'(i + 1));
        end
        rd(8'h2c, UNMAPPED_RDATA);
        rd(8'h26, UNMAPPED_RDATA);
    endtask

    task automatic t_a31;
        logic [7:0] t = 8'h96;
        mode_a = PLDLUT_MODE_3TO1;
        mode_b = PLDLUT_MODE_GPIO;
        wr(LUT_A_FIRST_OFS, t);
        for (int s = 0; s < 8; s++) begin
            pins(3'(s), {3'b000, t[s]}, 4'b1110);
        end
    endtask

    task automatic t_32;
        logic [7:0] a2 = 8'h35, a3 = 8'hc9, b2 = 8'h5a, b3 = 8'he1;
        mode_a = PLDLUT_MODE_3TO2;
        mode_b = PLDLUT_MODE_3TO2;
        wr(LUT_A_SECOND_OFS, a2);
        wr(LUT_A_THIRD_OFS, a3);
        wr(LUT_B_SECOND_OFS, b2);
        wr(LUT_B_THIRD_OFS, b3);
        for (int s = 0; s < 8; s++) begin
            pins(3'(s), {b3[s], b2[s], a3[s], a2[s]}, 4'b0000);
        end
    endtask

    // Bank A idle, B active; write latency; other modes; reset in mid-run
    task automatic t_mixed;
        mode_a = PLDLUT_MODE_GPIO;
        mode_b = PLDLUT_MODE_3TO2;
        wr(LUT_B_SECOND_OFS, 8'h0f);
        wr(LUT_B_THIRD_OFS, 8'hf0);
        pins(3'h2, 4'b0100, 4'b0011);
        wr(LUT_B_SECOND_OFS, 8'h00);
        @(negedge core_clk);
        `CHK("line 11 after write", 1'b0, io_out[B_OUT_FIRST])
        rd(LUT_B_THIRD_OFS, 8'hf0);
        repeat (3) @(negedge core_clk);
        `CHK("rdata held", 8'hf0, reg_rdata)
        mode_a = PLDLUT_MODE_RSVD;
        mode_b = PLDLUT_MODE_3TO1;
        pins(3'h2, 4'b0000, 4'b1111);
        @(negedge core_clk);
        rst = 1'b1;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        `CHK("oe_n after reset", 16'hffff, io_oe_n)
        rd(LUT_B_THIRD_OFS, LUT_RESET);
        rd(LUT_A_FIRST_OFS, LUT_RESET);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_regs();
        t_a31();
        t_32();
        t_mixed();
        summarize();
    end
endmodule // pldlut_top_bench
